/* File: pkg/ssech_pkg.sv */
/*
  ssech_pkg: constants, register map and state encoding shared by the
  effecter state command handler and its apb test.
  Assumes a 100 MHz clock and a byte-addressed APB register window.
*/
`default_nettype none

package ssech_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_NS = 10;
  localparam int SETTLE_NS = 160;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_HANDLE = 8'h08;
  localparam logic [7:0] OFF_COUNT = 8'h0C;
  localparam logic [7:0] OFF_ADMIN = 8'h10;
  localparam logic [7:0] OFF_RESULT = 8'h14;
  localparam logic [7:0] OFF_SETREC = 8'h20;
  localparam logic [7:0] OFF_RESP = 8'h40;
  localparam logic [7:0] BLK_SPAN = 8'h20;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_SET_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_PEND_BIT = 2;
  localparam int BYTE1_LSB = 8;
  localparam int BYTE2_LSB = 16;
  localparam int ADM_COND_LSB = 8;
  localparam int ADM_OFF_LSB = 10;
  localparam int ADM_IDX_LSB = 13;

  // ************************************************************
  // result codes, selector and condition encodings
  // ************************************************************
  localparam logic [7:0] RC_SUCCESS = 8'h00;
  localparam logic [7:0] RC_INV_DATA = 8'h02;
  localparam logic [7:0] RC_UNKNOWN_HANDLE = 8'h80;
  localparam logic [7:0] RC_INVALID_STATE = 8'h81;
  localparam logic [7:0] RC_UNSUPPORTED_STATE = 8'h82;
  localparam logic [7:0] SEL_KEEP_CURRENT = 8'h00;
  localparam logic [7:0] SEL_APPLY_TARGET = 8'h01;
  localparam logic [1:0] COND_EN_PEND = 2'h0;
  localparam logic [1:0] COND_EN_IDLE = 2'h1;
  localparam logic [1:0] COND_DISABLED = 2'h2;
  localparam logic [1:0] COND_UNAVAIL = 2'h3;
  localparam logic [15:0] HND_RSV_LO = 16'h0000;
  localparam logic [15:0] HND_RSV_HI = 16'hFFFF;
  localparam logic [7:0] CNT_MIN = 8'h01;
  localparam logic [7:0] CNT_MAX = 8'h08;
  localparam logic [7:0] UNK_STATE = 8'h00;
  localparam int SLOT_W = 18;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [15:0] RST_HANDLE = 16'h0000;
  localparam logic [7:0] RST_COUNT = 8'h01;

  typedef enum logic [6:0] {
    ST_INIT = 7'h01,
    ST_IDLE = 7'h02,
    ST_CHK = 7'h04,
    ST_WR = 7'h08,
    ST_GET = 7'h10,
    ST_COMMIT = 7'h20,
    ST_SPARE = 7'h40
  } ssech_state_e;

endpackage : ssech_pkg

`default_nettype wire

/* File: hdl/ssech_mem.sv */
/*
  ssech_mem: slot memory, one word per sub-actuator, registered read.
  Assumes the owner never relies on read data in the cycle of the address.
*/
`timescale 1ns/10ps
`default_nettype none

module ssech_mem #(
  parameter int W = 18,
  parameter int AW = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] wa,
  input wire logic [W-1:0] wd,
  // read port
  input wire logic [AW-1:0] ra,
  output logic [W-1:0] rd
);

  logic [W-1:0] mem_r [2**AW];
  logic [W-1:0] rd_r;

  // storage write
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem_r[wa] <= wd;
    end
  end

  // read data register, old data on collision
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rd_r <= '0;
    end
    else
    begin
      rd_r <= mem_r[ra];
    end
  end

  assign rd = rd_r;

endmodule : ssech_mem

`default_nettype wire

/* File: hdl/ssech_top.sv */
/*
  ssech_top: set-states / get-states command handler for state actuators,
  driven by software over APB.
  Assumes an APB master on clk; N_ACT of at least 2.
*/
//
// Contract
// - a record with the keep-current selector leaves its slot alone.
// - a record with apply-target drives the slot to its target value.
// - target values are checked against each actuator's own state set; the code checks every actuator against the one range 1..MAX_STATE.
// - a get request carries a 16-bit handle naming an actuator.
// - handles 0x0000 and 0xFFFF are never valid actuators.
// - an unmatched handle answers 0x80, else base codes are used.
// - a get answer carries a count byte from 0x01 to 0x08.
// - one handle spans up to eight offsets 0..7, returned in order.
// - one record is returned per counted sub-actuator.
// - each record is condition byte then awaited state byte.
// - conditions include enabled variants, disabled=2 and unavailable.
// - while pending the awaited value is returned, else the present one; the code returns 0 for disabled and unavailable slots.
// - set rejects 0x81 bad value, 0x82 unsupported, 0x80 bad handle.
`timescale 1ns/10ps
`default_nettype none

module ssech_top #(
  parameter int N_ACT = 4,
  parameter int SUBS = 8,
  parameter logic [15:0] HANDLE_BASE = 16'h0001,
  parameter logic [7:0] MAX_STATE = 8'h0F,
  parameter int SETTLE_CYC = ssech_pkg::SETTLE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // actuator drive
  output logic act_set_valid,
  output logic [15:0] act_set_handle,
  output logic [2:0] act_set_off,
  output logic [7:0] act_set_value
);

  localparam int IW = $clog2(N_ACT);
  localparam int AW = IW + 3;
  localparam int SW = ssech_pkg::SLOT_W;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic hnd_ok(input logic [15:0] h);
    logic [15:0] d;
    d = h - HANDLE_BASE;
    hnd_ok = (h != ssech_pkg::HND_RSV_LO) && (h != ssech_pkg::HND_RSV_HI)
      && (h >= HANDLE_BASE) && (d < 16'(N_ACT));
  endfunction : hnd_ok

  function automatic logic in_blk(input logic [7:0] a,
    input logic [7:0] base);
    in_blk = (a >= base) && (a < base + ssech_pkg::BLK_SPAN);
  endfunction : in_blk

  // ************************************************************
  // state
  // ************************************************************
  ssech_pkg::ssech_state_e state_r;
  logic pready_r, pslverr_r, go_r, go_set_r, done_r, arm_r, adm_r;
  logic [31:0] prdata_r;
  logic [15:0] handle_r, timer_r;
  logic [7:0] count_r, rc_r, rcnt_r, rlen_r, chk_rc_r, cmd_rc;
  logic [7:0] rec_sel_r [8];
  logic [7:0] rec_val_r [8];
  logic [7:0] cur_r [8];
  logic [7:0] resp_cond_r [8];
  logic [7:0] resp_st_r [8];
  logic [SW-1:0] adm_wd_r, wd, rdat;
  logic [AW-1:0] adm_wa_r, wa, ra, init_cnt_r;
  logic [IW-1:0] idx_r, cidx_r;
  logic [3:0] ptr_r, lim_r;
  logic [2:0] rd_off_r;
  logic rd_v_r, we, last_rd, issue, busy, applied_r;
  logic act_v_r;
  logic [15:0] act_h_r;
  logic [2:0] act_o_r;
  logic [7:0] act_val_r;

  logic xfer, wr_ok, map_ok, ro_reg;
  logic [31:0] rd_mux;
  logic [1:0] r_cond;
  logic [7:0] r_awd, r_pres;

  assign r_cond = rdat[17:16];
  assign r_awd = rdat[15:8];
  assign r_pres = rdat[7:0];
  assign busy = (state_r != ssech_pkg::ST_IDLE) | go_r | adm_r;
  assign xfer = psel & penable & pready_r;
  assign wr_ok = xfer & pwrite & ~pslverr_r;
  assign issue = (state_r == ssech_pkg::ST_CHK
    || state_r == ssech_pkg::ST_GET
    || state_r == ssech_pkg::ST_COMMIT) && (ptr_r < lim_r);
  assign last_rd = rd_v_r && (4'(rd_off_r) == lim_r - 4'h1);
  assign ra = {(state_r == ssech_pkg::ST_COMMIT) ? cidx_r : idx_r,
    ptr_r[2:0]};

  // ************************************************************
  // apb register access
  // ************************************************************

  // read mux and decode
  always_comb
  begin
    rd_mux = '0;
    map_ok = 1'b1;
    ro_reg = 1'b0;
    case (paddr)
      ssech_pkg::OFF_CTRL: rd_mux = '0;
      ssech_pkg::OFF_STATUS:
      begin
        ro_reg = 1'b1;
        rd_mux[ssech_pkg::STAT_BUSY_BIT] = busy;
        rd_mux[ssech_pkg::STAT_DONE_BIT] = done_r;
        rd_mux[ssech_pkg::STAT_PEND_BIT] = arm_r;
      end
      ssech_pkg::OFF_HANDLE: rd_mux[15:0] = handle_r;
      ssech_pkg::OFF_COUNT: rd_mux[7:0] = count_r;
      ssech_pkg::OFF_ADMIN: rd_mux = '0;
      ssech_pkg::OFF_RESULT:
      begin
        ro_reg = 1'b1;
        rd_mux = {8'h00, rlen_r, rcnt_r, rc_r};
      end
      default:
      begin
        if (in_blk(paddr, ssech_pkg::OFF_SETREC))
        begin
          rd_mux = {16'h0000, rec_val_r[paddr[4:2]],
            rec_sel_r[paddr[4:2]]};
        end
        else if (in_blk(paddr, ssech_pkg::OFF_RESP))
        begin
          ro_reg = 1'b1;
          // slots past the count read zero
          if (5'(paddr[4:2]) < 5'(rcnt_r))
          begin
            rd_mux = {16'h0000, resp_st_r[paddr[4:2]],
              resp_cond_r[paddr[4:2]]};
          end
        end
        else
        begin
          map_ok = 1'b0;
        end
      end
    endcase
    if (paddr[1:0] != 2'h0)
    begin
      map_ok = 1'b0;
    end
  end

  // one wait state, answer registered
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end
    else
    begin
      pready_r <= psel & penable & ~pready_r;
      if (psel & penable & ~pready_r)
      begin
        pslverr_r <= ~map_ok | (pwrite & (ro_reg | busy));
        prdata_r <= (map_ok & ~pwrite) ? rd_mux : '0;
      end
      else
      begin
        pslverr_r <= 1'b0;
        prdata_r <= '0;
      end
    end
  end

  // request registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      handle_r <= ssech_pkg::RST_HANDLE;
      count_r <= ssech_pkg::RST_COUNT;
      for (int i = 0; i < 8; i++)
      begin
        rec_sel_r[i] <= ssech_pkg::SEL_KEEP_CURRENT;
        rec_val_r[i] <= ssech_pkg::UNK_STATE;
      end
    end
    else if (wr_ok)
    begin
      if (paddr == ssech_pkg::OFF_HANDLE)
      begin
        handle_r <= pwdata[15:0];
      end
      if (paddr == ssech_pkg::OFF_COUNT)
      begin
        count_r <= pwdata[7:0];
      end
      if (in_blk(paddr, ssech_pkg::OFF_SETREC))
      begin
        rec_sel_r[paddr[4:2]] <= pwdata[7:0];
        rec_val_r[paddr[4:2]] <= pwdata[ssech_pkg::BYTE1_LSB +: 8];
      end
    end
  end

  // command and slot-admin requests
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      go_r <= 1'b0;
      go_set_r <= 1'b0;
      adm_r <= 1'b0;
      adm_wa_r <= '0;
      adm_wd_r <= '0;
    end
    else
    begin
      if (wr_ok && paddr == ssech_pkg::OFF_CTRL
        && pwdata[ssech_pkg::CTRL_GO_BIT])
      begin
        go_r <= 1'b1;
        go_set_r <= pwdata[ssech_pkg::CTRL_SET_BIT];
      end
      else if (state_r == ssech_pkg::ST_IDLE && !adm_r
        && !(arm_r && (timer_r == 16'h0000 || go_set_r)))
      begin
        go_r <= 1'b0;
      end
      if (wr_ok && paddr == ssech_pkg::OFF_ADMIN)
      begin
        adm_r <= 1'b1;
        adm_wa_r <= {pwdata[ssech_pkg::ADM_IDX_LSB +: IW],
          pwdata[ssech_pkg::ADM_OFF_LSB +: 3]};
        adm_wd_r <= {pwdata[ssech_pkg::ADM_COND_LSB +: 2],
          pwdata[7:0], pwdata[7:0]};
      end
      else if (state_r == ssech_pkg::ST_IDLE)
      begin
        adm_r <= 1'b0;
      end
    end
  end

  // ************************************************************
  // slot memory
  // ************************************************************

  // write port mux
  always_comb
  begin
    we = 1'b0;
    wa = '0;
    wd = '0;
    case (state_r)
      ssech_pkg::ST_INIT:
      begin
        we = 1'b1;
        wa = init_cnt_r;
        wd = {ssech_pkg::COND_DISABLED, ssech_pkg::UNK_STATE,
          ssech_pkg::UNK_STATE};
      end
      ssech_pkg::ST_IDLE:
      begin
        we = adm_r;
        wa = adm_wa_r;
        wd = adm_wd_r;
      end
      ssech_pkg::ST_WR:
      begin
        // keep-current records are skipped
        if (ptr_r < lim_r
          && rec_sel_r[ptr_r[2:0]] == ssech_pkg::SEL_APPLY_TARGET)
        begin
          we = 1'b1;
          wa = {idx_r, ptr_r[2:0]};
          wd = {ssech_pkg::COND_EN_PEND, rec_val_r[ptr_r[2:0]],
            cur_r[ptr_r[2:0]]};
        end
      end
      ssech_pkg::ST_COMMIT:
      begin
        if (rd_v_r && r_cond == ssech_pkg::COND_EN_PEND)
        begin
          we = 1'b1;
          wa = {cidx_r, rd_off_r};
          wd = {ssech_pkg::COND_EN_IDLE, r_awd, r_awd};
        end
      end
      default: we = 1'b0;
    endcase
  end

  ssech_mem #(.W(SW), .AW(AW)) u_mem (
    .clk(clk),
    .srst(srst),
    .we(we),
    .wa(wa),
    .wd(wd),
    .ra(ra),
    .rd(rdat)
  );

  // ************************************************************
  // set record check
  // ************************************************************

  // error of the record coming back from memory
  always_comb
  begin
    cmd_rc = ssech_pkg::RC_SUCCESS;
    if (rec_sel_r[rd_off_r] == ssech_pkg::SEL_APPLY_TARGET)
    begin
      if (rec_val_r[rd_off_r] == ssech_pkg::UNK_STATE
        || rec_val_r[rd_off_r] > MAX_STATE)
      begin
        cmd_rc = ssech_pkg::RC_INVALID_STATE;
      end
      else if (r_cond == ssech_pkg::COND_DISABLED
        || r_cond == ssech_pkg::COND_UNAVAIL)
      begin
        cmd_rc = ssech_pkg::RC_UNSUPPORTED_STATE;
      end
    end
    else if (rec_sel_r[rd_off_r] != ssech_pkg::SEL_KEEP_CURRENT)
    begin
      cmd_rc = ssech_pkg::RC_INV_DATA;
    end
    if (chk_rc_r != ssech_pkg::RC_SUCCESS)
    begin
      cmd_rc = chk_rc_r;
    end
  end

  // ************************************************************
  // command sequencer
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_r <= ssech_pkg::ST_INIT;
      init_cnt_r <= '0;
      ptr_r <= '0;
      lim_r <= '0;
      idx_r <= '0;
      rd_v_r <= 1'b0;
      rd_off_r <= '0;
      chk_rc_r <= ssech_pkg::RC_SUCCESS;
      rc_r <= ssech_pkg::RC_SUCCESS;
      rcnt_r <= '0;
      rlen_r <= '0;
      done_r <= 1'b0;
      applied_r <= 1'b0;
      for (int i = 0; i < 8; i++)
      begin
        cur_r[i] <= ssech_pkg::UNK_STATE;
        resp_cond_r[i] <= '0;
        resp_st_r[i] <= '0;
      end
    end
    else
    begin
      rd_v_r <= issue;
      rd_off_r <= ptr_r[2:0];
      if (issue)
      begin
        ptr_r <= ptr_r + 4'h1;
      end
      case (state_r)
        ssech_pkg::ST_INIT:
        begin
          init_cnt_r <= init_cnt_r + 1'b1;
          if (init_cnt_r == AW'(2**AW - 1))
          begin
            state_r <= ssech_pkg::ST_IDLE;
          end
        end
        ssech_pkg::ST_IDLE:
        begin
          ptr_r <= '0;
          chk_rc_r <= ssech_pkg::RC_SUCCESS;
          applied_r <= 1'b0;
          if (adm_r)
          begin
            state_r <= ssech_pkg::ST_IDLE;
          end
          else if (arm_r && (timer_r == 16'h0000 || (go_r && go_set_r)))
          begin
            lim_r <= 4'(SUBS);
            state_r <= ssech_pkg::ST_COMMIT;
          end
          else if (go_r)
          begin
            done_r <= 1'b0;
            idx_r <= IW'(handle_r - HANDLE_BASE);
            rcnt_r <= '0;
            rlen_r <= 8'h01;
            if (!hnd_ok(handle_r))
            begin
              rc_r <= ssech_pkg::RC_UNKNOWN_HANDLE;
              done_r <= 1'b1;
            end
            else if (go_set_r && (count_r < ssech_pkg::CNT_MIN
              || count_r > ssech_pkg::CNT_MAX
              || count_r > 8'(SUBS)))
            begin
              rc_r <= ssech_pkg::RC_INV_DATA;
              done_r <= 1'b1;
            end
            else if (go_set_r)
            begin
              lim_r <= count_r[3:0];
              state_r <= ssech_pkg::ST_CHK;
            end
            else
            begin
              lim_r <= 4'(SUBS);
              state_r <= ssech_pkg::ST_GET;
            end
          end
        end
        ssech_pkg::ST_CHK:
        begin
          if (rd_v_r)
          begin
            cur_r[rd_off_r] <= r_pres;
            chk_rc_r <= cmd_rc;
          end
          if (last_rd)
          begin
            ptr_r <= '0;
            if (cmd_rc != ssech_pkg::RC_SUCCESS)
            begin
              rc_r <= cmd_rc;
              done_r <= 1'b1;
              state_r <= ssech_pkg::ST_IDLE;
            end
            else
            begin
              state_r <= ssech_pkg::ST_WR;
            end
          end
        end
        ssech_pkg::ST_WR:
        begin
          ptr_r <= ptr_r + 4'h1;
          if (we)
          begin
            applied_r <= 1'b1;
          end
          if (ptr_r == lim_r - 4'h1)
          begin
            rc_r <= ssech_pkg::RC_SUCCESS;
            done_r <= 1'b1;
            state_r <= ssech_pkg::ST_IDLE;
          end
        end
        ssech_pkg::ST_GET:
        begin
          if (rd_v_r)
          begin
            resp_cond_r[rd_off_r] <= {6'h00, r_cond};
            if (r_cond == ssech_pkg::COND_EN_PEND)
            begin
              resp_st_r[rd_off_r] <= r_awd;
            end
            else if (r_cond == ssech_pkg::COND_EN_IDLE)
            begin
              resp_st_r[rd_off_r] <= r_pres;
            end
            else
            begin
              resp_st_r[rd_off_r] <= ssech_pkg::UNK_STATE;
            end
          end
          if (last_rd)
          begin
            rc_r <= ssech_pkg::RC_SUCCESS;
            rcnt_r <= 8'(SUBS);
            rlen_r <= 8'(2 + 2 * SUBS);
            done_r <= 1'b1;
            state_r <= ssech_pkg::ST_IDLE;
          end
        end
        ssech_pkg::ST_COMMIT:
        begin
          if (last_rd)
          begin
            state_r <= ssech_pkg::ST_IDLE;
          end
        end
        default: state_r <= ssech_pkg::ST_IDLE;
      endcase
    end
  end

  // settle timer and pending flag
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      arm_r <= 1'b0;
      timer_r <= '0;
      cidx_r <= '0;
    end
    else if (state_r == ssech_pkg::ST_WR && ptr_r == lim_r - 4'h1)
    begin
      arm_r <= applied_r | we;
      timer_r <= 16'(SETTLE_CYC);
      cidx_r <= idx_r;
    end
    else if (state_r == ssech_pkg::ST_COMMIT && last_rd)
    begin
      arm_r <= 1'b0;
    end
    else if (timer_r != 16'h0000)
    begin
      timer_r <= timer_r - 16'h0001;
    end
  end

  // actuator drive pulse on commit
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      act_v_r <= 1'b0;
      act_h_r <= '0;
      act_o_r <= '0;
      act_val_r <= '0;
    end
    else
    begin
      act_v_r <= (state_r == ssech_pkg::ST_COMMIT) && we;
      if ((state_r == ssech_pkg::ST_COMMIT) && we)
      begin
        act_h_r <= HANDLE_BASE + 16'(cidx_r);
        act_o_r <= rd_off_r;
        act_val_r <= r_awd;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign act_set_valid = act_v_r;
  assign act_set_handle = act_h_r;
  assign act_set_off = act_o_r;
  assign act_set_value = act_val_r;

endmodule : ssech_top

`default_nettype wire

/* File: verif/ssech_top_checker.sv */
/*
  ssech_top_checker: port assertions for ssech_top.
  Assumes binding onto ssech_top; one clock, sync reset.
*/
`timescale 1ns/10ps
`default_nettype none

module ssech_top_checker #(
  parameter logic [7:0] MAX_STATE = 8'h0F
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // actuator drive
  input wire logic act_set_valid,
  input wire logic [15:0] act_set_handle,
  input wire logic [7:0] act_set_value
);
  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  logic rd_ok;
  // good read answer
  assign rd_ok = pready && !pwrite && !pslverr;
  property p_lat;
    psel && $rose(penable) |-> !pready ##1 pready;
  endproperty
  a_lat: assert property (p_lat) else $error("apb wait wrong");
  property p_unmap;
    pready && paddr == 8'h18 |-> pslverr && prdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped accepted");
  property p_rec;
    rd_ok && paddr[7:5] == 3'h2 |-> prdata[31:16] == 16'h0 &&
      prdata[7:0] <= 8'h03;
  endproperty
  a_rec: assert property (p_rec) else $error("record bad");
  property p_unk;
    rd_ok && paddr[7:5] == 3'h2 && prdata[1] |-> prdata[15:8] == 8'h0;
  endproperty
  a_unk: assert property (p_unk) else $error("state not unknown");
  property p_err;
    rd_ok && paddr == 8'h14 && prdata[7:0] == 8'h80 |->
      prdata[23:8] == 16'h0100;
  endproperty
  a_err: assert property (p_err) else $error("error answer long");
  property p_len;
    rd_ok && paddr == 8'h14 && prdata[7:0] == 8'h0 &&
      prdata[23:16] != 8'h1 |-> prdata[15:8] inside {[8'h1:8'h8]} &&
      prdata[23:16] == 8'(2 + 2 * prdata[15:8]);
  endproperty
  a_len: assert property (p_len) else $error("count bad");
  property p_val;
    act_set_valid |-> act_set_value inside {[8'h1:MAX_STATE]};
  endproperty
  a_val: assert property (p_val) else $error("bad value");
  property p_hnd;
    act_set_valid |-> act_set_handle != 16'h0 &&
      act_set_handle != 16'hFFFF;
  endproperty
  a_hnd: assert property (p_hnd) else $error("reserved handle");
endmodule : ssech_top_checker

bind ssech_top ssech_top_checker #(.MAX_STATE(MAX_STATE)) u_chk (
  .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .act_set_valid(act_set_valid), .act_set_handle(act_set_handle),
  .act_set_value(act_set_value));

`default_nettype wire

/* File: verif/ssech_act_model.sv */
/*
  ssech_act_model: bank of sub-actuators fed by the handler.
  Assumes one pulse per committed value.
*/
`timescale 1ns/10ps
`default_nettype none

module ssech_act_model (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // actuator drive
  input wire logic act_set_valid,
  input wire logic [15:0] act_set_handle,
  input wire logic [2:0] act_set_off,
  input wire logic [7:0] act_set_value
);
  // ************************************************************
  // sub-actuator latches
  // ************************************************************
  int n_pulse;
  logic [7:0] last [8];
  logic [15:0] hnd;
  // take each committed value
  always @(posedge clk)
  begin
    if (srst)
    begin
      n_pulse <= 0;
      last <= '{default: 8'h0};
      hnd <= 16'h0;
    end
    else if (act_set_valid)
    begin
      n_pulse <= n_pulse + 1;
      last[act_set_off] <= act_set_value;
      hnd <= act_set_handle;
    end
  end
endmodule : ssech_act_model

`default_nettype wire

/* File: verif/ssech_top_test.sv */
/*
  ssech_top_test: apb-level tests of the command handler.
  Assumes ssech_top, its bound checker and ssech_act_model.
*/
`timescale 1ns/10ps
`default_nettype none

module ssech_top_test;
  // ************************************************************
  // bench
  // ************************************************************
  logic clk, srst, psel, penable, pwrite, pready, pslverr, e, av;
  logic [7:0] paddr, aval;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] ah;
  logic [2:0] ao;
  logic [15:0] bad [3] = '{16'h0, 16'hFFFF, 16'h5};
  logic [55:0] errs [8] = '{56'h81_0001_0100_0100, 56'h81_0001_0100_0110,
    56'h02_0001_0100_0205, 56'h82_0001_0403_0105, 56'h02_0001_0000_0105,
    56'h02_0001_0900_0105, 56'h80_0000_0100_0105, 56'h80_FFFF_0100_0105};
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;

  ssech_top #(.SETTLE_CYC(80)) dut (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .act_set_valid(av), .act_set_handle(ah), .act_set_off(ao),
    .act_set_value(aval));
  ssech_act_model act (.clk(clk), .srst(srst), .act_set_valid(av),
    .act_set_handle(ah), .act_set_off(ao), .act_set_value(aval));

  // clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task print_verdict();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      print_verdict();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, held until pready
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : xfer

  // start a command and poll for done
  task cmd(input logic set);
    xfer(1'b1, ssech_pkg::OFF_CTRL, {30'h0, set, 1'b1});
    r = 32'h0;
    while (r[1] !== 1'b1)
      xfer(1'b0, ssech_pkg::OFF_STATUS, 32'h0);
    xfer(1'b0, ssech_pkg::OFF_RESULT, 32'h0);
  endtask : cmd

  task resp(input int i, input logic [31:0] exp);
    xfer(1'b0, 8'(ssech_pkg::OFF_RESP + 4 * i), 32'h0);
    chk(r, exp);
  endtask : resp

  // main sequence
  initial
  begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    r = 32'h1;
    while (r[0] !== 1'b0)
      xfer(1'b0, ssech_pkg::OFF_STATUS, 32'h0);
    xfer(1'b0, ssech_pkg::OFF_COUNT, 32'h0);
    chk(r, 32'h1);
    xfer(1'b0, 8'h18, 32'h0);
    chk({e, r[30:0]}, 32'h8000_0000);
    xfer(1'b1, ssech_pkg::OFF_STATUS, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("test registers done");
    for (int i = 0; i < 8; i++)
      xfer(1'b1, ssech_pkg::OFF_ADMIN,
        {19'h0, i[2:0], (i == 3) ? 2'h2 : 2'h1, 8'(i + 1)});
    foreach (bad[k])
    begin
      xfer(1'b1, ssech_pkg::OFF_HANDLE, {16'h0, bad[k]});
      cmd(1'b0);
      chk(r, 32'h0001_0080);
    end
    xfer(1'b1, ssech_pkg::OFF_HANDLE, 32'h1);
    cmd(1'b0);
    chk(r, 32'h0012_0800);
    for (int i = 0; i < 8; i++)
      resp(i, (i == 3) ? 32'h2 : {16'h0, 8'(i + 1), 8'h1});
    $display("test get done");
    xfer(1'b1, ssech_pkg::OFF_SETREC, 32'h0901);
    xfer(1'b1, 8'h24, 32'h0700);
    xfer(1'b1, 8'h28, 32'h0C01);
    xfer(1'b1, ssech_pkg::OFF_COUNT, 32'h3);
    cmd(1'b1);
    chk({8'h0, r[23:16], 8'h0, r[7:0]}, 32'h0001_0000);
    xfer(1'b0, ssech_pkg::OFF_STATUS, 32'h0);
    chk(r, 32'h6);
    cmd(1'b0);
    resp(0, 32'h0900);
    resp(1, 32'h0201);
    resp(2, 32'h0C00);
    repeat (200) @(posedge clk);
    chk(act.n_pulse, 32'h2);
    chk({24'h0, act.last[0]}, 32'h9);
    chk({24'h0, act.last[2]}, 32'hC);
    chk({16'h0, act.hnd}, 32'h1);
    xfer(1'b0, ssech_pkg::OFF_STATUS, 32'h0);
    chk(r, 32'h2);
    cmd(1'b0);
    resp(0, 32'h0901);
    $display("test set done");
    foreach (errs[k])
    begin
      xfer(1'b1, ssech_pkg::OFF_HANDLE, {16'h0, errs[k][47:32]});
      xfer(1'b1, ssech_pkg::OFF_COUNT, {24'h0, errs[k][31:24]});
      for (int j = 0; j <= errs[k][23:16]; j++)
        xfer(1'b1, 8'(ssech_pkg::OFF_SETREC + 4 * j),
          (j == errs[k][23:16]) ? {16'h0, errs[k][7:0], errs[k][15:8]} : 0);
      cmd(1'b1);
      chk({24'h0, r[7:0]}, {24'h0, errs[k][55:48]});
    end
    repeat (200) @(posedge clk);
    chk(act.n_pulse, 32'h2);
    $display("test set errors done");
    print_verdict();
  end
endmodule : ssech_top_test

`default_nettype wire
